// [prcd_pkg.sv]
// Constants and types for the page region command decoder
package prcd_pkg;
  localparam logic [7:0] ESC_BYTE = 8'h1b;
  localparam logic [7:0] OP_REGION = 8'h57;
  localparam logic [7:0] OP_ROTATE = 8'h56;
  localparam logic [7:0] ROT_OFF_A = 8'h00;
  localparam logic [7:0] ROT_OFF_B = 8'h30;
  localparam logic [7:0] ROT_ON_A = 8'h01;
  localparam logic [7:0] ROT_ON_B = 8'h31;
  localparam logic [2:0] PARAM_LAST = 3'h7;
  localparam int IDX_XL = 0;
  localparam int IDX_XH = 1;
  localparam int IDX_YL = 2;
  localparam int IDX_YH = 3;
  localparam int IDX_WL = 4;
  localparam int IDX_WH = 5;
  localparam int IDX_HL = 6;
  localparam int IDX_HH = 7;
  localparam logic [7:0] REGION_BYTE_RST = 8'h00;
  localparam logic ROT_RST = 1'b0;
  localparam logic [15:0] PRINT_W_3IN = 16'h0240;
  localparam logic [15:0] PRINT_W_2IN = 16'h01b0;
  localparam logic [15:0] PRINT_H = 16'h0300;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ESC,
    ST_PARAM,
    ST_ROT
  } prcd_state_t;
endpackage : prcd_pkg

// [prcd_pair_if.sv]
// Low/high byte pair with its pitch and scaled result
`timescale 1ns/1ps
interface prcd_pair_if #(
  parameter int PITCH_W = 8
);
  logic [7:0] lo;
  logic [7:0] hi;
  logic [PITCH_W-1:0] pitch;
  logic [16+PITCH_W-1:0] value;

  modport src (output lo, output hi, output pitch, input value);
  modport scaler (input lo, input hi, input pitch, output value);
endinterface : prcd_pair_if

// [prcd_pair_scale.sv]
// Scales a low/high byte pair by the basic pitch
`timescale 1ns/1ps
module prcd_pair_scale #(
  parameter int PITCH_W = 8
) (
  prcd_pair_if.scaler p
);
  localparam int VAL_W = 16 + PITCH_W;
  wire [VAL_W-1:0] pair_w = VAL_W'({p.hi, p.lo});
  wire [VAL_W-1:0] pitch_w = VAL_W'(p.pitch);

  assign p.value = pair_w * pitch_w;
endmodule : prcd_pair_scale

// [prcd_clip.sv]
// Clips a length so that start plus length stays inside the printable extent
`timescale 1ns/1ps
module prcd_clip #(
  parameter int W = 24
) (
  input wire logic [W-1:0] start_in,
  input wire logic [W-1:0] len_in,
  input wire logic [W-1:0] limit_in,
  output logic [W-1:0] len_out
);
  wire [W:0] reach = {1'b0, start_in} + {1'b0, len_in};
  wire past_end = reach > {1'b0, limit_in};
  wire start_out = start_in >= limit_in;

  // A start already outside the area leaves nothing printable
  assign len_out = start_out ? '0 : (past_end ? limit_in - start_in : len_in);
endmodule : prcd_clip

// [prcd_decoder.sv]
// Page region and rotation command decoder
`timescale 1ns/1ps
module prcd_decoder
  import prcd_pkg::*;
#(
  parameter int PITCH_W = 8
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [7:0] cmd_byte_in,
  input wire logic cmd_valid_in,
  input wire logic [PITCH_W-1:0] pitch_in,
  input wire logic paper_two_inch_in,
  input wire logic page_mode_enter_in,
  input wire logic std_mode_enter_in,
  output logic [16+PITCH_W-1:0] x_start_out,
  output logic [16+PITCH_W-1:0] y_start_out,
  output logic [16+PITCH_W-1:0] width_out,
  output logic [16+PITCH_W-1:0] height_out,
  output logic region_update_out,
  output logic region_reject_out,
  output logic page_mode_out,
  output logic rotate_setting_out,
  output logic rotate_single_byte_alnum_kana_out,
  output logic rotate_double_byte_out
);
  localparam int VAL_W = 16 + PITCH_W;

  prcd_state_t state_r;
  prcd_state_t state_nxt;
  logic [2:0] cnt_r;
  logic [7:0] pbuf_r [0:7];
  logic [7:0] region_r [0:7];
  logic [PITCH_W-1:0] pitch_r;
  logic page_mode_r;
  logic rot_setting_r;
  logic rot_print_r;
  logic apply_r;
  logic reject_r;
  logic update_r;
  logic [VAL_W-1:0] x_start_r;
  logic [VAL_W-1:0] y_start_r;
  logic [VAL_W-1:0] width_r;
  logic [VAL_W-1:0] height_r;

  // Byte stream decoding
  wire is_esc = cmd_byte_in == ESC_BYTE;
  wire param_final = cmd_valid_in && state_r == ST_PARAM && cnt_r == PARAM_LAST;
  wire rot_final = cmd_valid_in && state_r == ST_ROT;
  wire zero_width = pbuf_r[IDX_WL] == 8'h00 && pbuf_r[IDX_WH] == 8'h00;
  wire zero_height = pbuf_r[IDX_HL] == 8'h00 && cmd_byte_in == 8'h00;
  wire zero_dim = zero_width || zero_height;
  wire region_take = param_final && !page_mode_r && !zero_dim;
  wire region_drop = param_final && (page_mode_r || zero_dim);
  wire rot_on_val = cmd_byte_in == ROT_ON_A || cmd_byte_in == ROT_ON_B;
  wire rot_off_val = cmd_byte_in == ROT_OFF_A || cmd_byte_in == ROT_OFF_B;
  wire rot_on_cmd = rot_final && rot_on_val;
  wire rot_off_cmd = rot_final && rot_off_val;
  wire rot_setting_nxt = rot_on_cmd ? 1'b1 : (rot_off_cmd ? 1'b0 : rot_setting_r);
  wire page_mode_nxt = std_mode_enter_in ? 1'b0 : (page_mode_enter_in ? 1'b1 : page_mode_r);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (cmd_valid_in && is_esc) begin
          state_nxt = ST_ESC;
        end
      end
      ST_ESC: begin
        if (cmd_valid_in) begin
          if (cmd_byte_in == OP_REGION) begin
            state_nxt = ST_PARAM;
          end else if (cmd_byte_in == OP_ROTATE) begin
            state_nxt = ST_ROT;
          end else if (is_esc) begin
            state_nxt = ST_ESC;
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_PARAM: begin
        if (param_final) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_ROT: begin
        if (cmd_valid_in) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_r <= ST_IDLE;
      cnt_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      if (state_r != ST_PARAM) begin
        cnt_r <= 3'h0;
      end else if (cmd_valid_in) begin
        cnt_r <= cnt_r + 3'h1;
      end
    end
  end

  // Parameter bytes arrive in fixed order and are filed by position
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      for (int i = 0; i < 8; i++) begin
        pbuf_r[i] <= 8'h00;
      end
    end else if (cmd_valid_in && state_r == ST_PARAM) begin
      pbuf_r[cnt_r] <= cmd_byte_in;
    end
  end

  // Accepted region bytes, held until the next accepted command
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      for (int i = 0; i < 8; i++) begin
        region_r[i] <= REGION_BYTE_RST;
      end
      pitch_r <= '0;
    end else if (region_take) begin
      for (int i = 0; i < 7; i++) begin
        region_r[i] <= pbuf_r[i];
      end
      region_r[IDX_HH] <= cmd_byte_in;
      pitch_r <= pitch_in;
    end
  end

  wire [7:0] x_start_low = region_r[IDX_XL];
  wire [7:0] x_start_high = region_r[IDX_XH];
  wire [7:0] y_start_low = region_r[IDX_YL];
  wire [7:0] y_start_high = region_r[IDX_YH];

  // Four scaled pairs: x start, y start, width, height
  logic [VAL_W-1:0] scaled [0:3];

  for (genvar g = 0; g < 4; g++) begin : g_pair
    prcd_pair_if #(.PITCH_W(PITCH_W)) pif ();
    assign pif.lo = region_r[2*g];
    assign pif.hi = region_r[2*g+1];
    assign pif.pitch = pitch_r;
    assign scaled[g] = pif.value;
    prcd_pair_scale #(.PITCH_W(PITCH_W)) u_scale (
      .p(pif.scaler)
    );
  end

  wire [VAL_W-1:0] x_raw = scaled[0];
  wire [VAL_W-1:0] y_raw = scaled[1];
  wire [VAL_W-1:0] w_raw = scaled[2];
  wire [VAL_W-1:0] h_raw = scaled[3];
  wire [VAL_W-1:0] limit_w = VAL_W'(paper_two_inch_in ? PRINT_W_2IN : PRINT_W_3IN);
  wire [VAL_W-1:0] limit_h = VAL_W'(PRINT_H);
  logic [VAL_W-1:0] w_clip;
  logic [VAL_W-1:0] h_clip;

  prcd_clip #(.W(VAL_W)) u_clip_w (
    .start_in(x_raw),
    .len_in(w_raw),
    .limit_in(limit_w),
    .len_out(w_clip)
  );

  prcd_clip #(.W(VAL_W)) u_clip_h (
    .start_in(y_raw),
    .len_in(h_raw),
    .limit_in(limit_h),
    .len_out(h_clip)
  );

  // Results are loaded one cycle after the bytes are accepted
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      apply_r <= 1'b0;
      reject_r <= 1'b0;
      update_r <= 1'b0;
    end else begin
      apply_r <= region_take;
      reject_r <= region_drop;
      update_r <= apply_r;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      x_start_r <= '0;
      y_start_r <= '0;
      width_r <= '0;
      height_r <= '0;
    end else if (apply_r) begin
      x_start_r <= x_raw;
      y_start_r <= y_raw;
      width_r <= w_clip;
      height_r <= h_clip;
    end
  end

  // Mode flag and rotation setting
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      page_mode_r <= 1'b0;
      rot_setting_r <= ROT_RST;
      rot_print_r <= ROT_RST;
    end else begin
      page_mode_r <= page_mode_nxt;
      rot_setting_r <= rot_setting_nxt;
      rot_print_r <= rot_setting_nxt && !page_mode_nxt;
    end
  end

  assign x_start_out = x_start_r;
  assign y_start_out = y_start_r;
  assign width_out = width_r;
  assign height_out = height_r;
  assign region_update_out = update_r;
  assign region_reject_out = reject_r;
  assign page_mode_out = page_mode_r;
  assign rotate_setting_out = rot_setting_r;
  assign rotate_single_byte_alnum_kana_out = rot_print_r;
  assign rotate_double_byte_out = rot_print_r;

  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  a_region_commit_time: assert property (region_take |=> ##1 region_update_out)
    else $error("accepted region command not published two cycles later");
  a_param_done_idle: assert property (param_final |=> state_r == ST_IDLE)
    else $error("decoder not idle after the last region byte");
  a_start_reset_zero: assert property ($past(reset_in) |->
      x_start_low == 8'h00 && x_start_high == 8'h00 && y_start_low == 8'h00 && y_start_high == 8'h00)
    else $error("start bytes not zero after reset");
  a_x_start_scale: assert property (region_update_out |->
      x_start_out == VAL_W'({x_start_high, x_start_low}) * VAL_W'(pitch_r))
    else $error("horizontal start not scaled by pitch");
  a_y_start_scale: assert property (region_update_out |->
      y_start_out == VAL_W'({y_start_high, y_start_low}) * VAL_W'(pitch_r))
    else $error("vertical start not scaled by pitch");
  // Paper width is read at the publish edge, one cycle before the update pulse is seen
  a_width_in_area: assert property (region_update_out && width_out != '0 |->
      x_start_out + width_out <= $past(limit_w))
    else $error("region width reaches past printable width");
  a_height_in_area: assert property (region_update_out && height_out != '0 |->
      y_start_out + height_out <= limit_h)
    else $error("region height reaches past printable height");
  a_width_clip_value: assert property (region_update_out && x_raw < $past(limit_w) &&
      {1'b0, x_raw} + {1'b0, w_raw} > {1'b0, $past(limit_w)} |-> width_out == $past(limit_w) - x_raw)
    else $error("width not clipped to printable width minus start");
  a_width_keep_value: assert property (region_update_out &&
      {1'b0, x_raw} + {1'b0, w_raw} <= {1'b0, $past(limit_w)} |-> width_out == w_raw)
    else $error("width changed although it fits");
  a_height_clip_value: assert property (region_update_out && y_raw < limit_h &&
      {1'b0, y_raw} + {1'b0, h_raw} > {1'b0, limit_h} |-> height_out == limit_h - y_raw)
    else $error("height not clipped to printable height minus start");
  a_height_keep_value: assert property (region_update_out &&
      {1'b0, y_raw} + {1'b0, h_raw} <= {1'b0, limit_h} |-> height_out == h_raw)
    else $error("height changed although it fits");
  a_region_hold: assert property (!apply_r |=>
      $stable(x_start_out) && $stable(y_start_out) && $stable(width_out) && $stable(height_out))
    else $error("region outputs changed without an accepted command");
  a_page_region_drop: assert property (param_final && page_mode_r |=> region_reject_out ##1 !region_update_out)
    else $error("region command acted in page mode");
  a_zero_dim_drop: assert property (param_final && zero_dim |=> region_reject_out ##1 !region_update_out)
    else $error("all-zero width or height was applied");
  a_reject_no_update: assert property (region_reject_out |-> !region_update_out)
    else $error("reject and update pulses together");
  a_rot_page_quiet: assert property (page_mode_r && $past(page_mode_r) |-> !rotate_double_byte_out)
    else $error("rotation reached page-mode output");
  a_rot_std_apply: assert property (rotate_double_byte_out == (rotate_setting_out && !page_mode_out))
    else $error("printed rotation does not follow setting in standard mode");
  a_rot_page_store: assert property (rot_on_cmd && page_mode_r && !std_mode_enter_in |=>
      rotate_setting_out && !rotate_single_byte_alnum_kana_out)
    else $error("page-mode rotation not stored or leaked to output");
  a_rot_on_value: assert property (rot_on_cmd |=> rotate_setting_out)
    else $error("rotation not turned on");
  a_rot_off_value: assert property (rot_off_cmd |=> !rotate_setting_out [*2])
    else $error("rotation not turned off");
  a_rot_both_sets: assert property (rotate_single_byte_alnum_kana_out == rotate_double_byte_out)
    else $error("rotation differs between character sets");
  a_mode_flag_use: assert property (std_mode_enter_in |=> !page_mode_out)
    else $error("standard mode not entered");
  a_page_mode_enter: assert property (page_mode_enter_in && !std_mode_enter_in |=> page_mode_out)
    else $error("page mode not entered");

  // Main scenarios
  c_region_update: cover property (region_take ##2 region_update_out);
  c_width_clipped: cover property (region_update_out && width_out != w_raw);
  c_rot_std_on: cover property (rot_on_cmd && !page_mode_r ##1 rotate_single_byte_alnum_kana_out);
  c_region_reject: cover property (region_reject_out);
  c_rot_page_store: cover property (rot_on_cmd && page_mode_r ##1 !rotate_single_byte_alnum_kana_out);
endmodule : prcd_decoder

// [prcd_host_model.sv]
// Host model that streams command bytes into the decoder
`timescale 1ns/1ps
module prcd_host_model
  import prcd_pkg::*;
(
  input wire logic mclk_in,
  output logic [7:0] cmd_byte_out,
  output logic cmd_valid_out
);
  initial begin
    cmd_byte_out = 8'h00;
    cmd_valid_out = 1'b0;
  end

  // One byte per clock, changed on the falling edge
  task automatic send_byte(input logic [7:0] b);
    cmd_byte_out = b;
    cmd_valid_out = 1'b1;
    @(negedge mclk_in);
  endtask : send_byte

  // A released bus shows the inverse of the last byte so a stale value never passes for data
  task automatic idle();
    cmd_valid_out = 1'b0;
    cmd_byte_out = ~cmd_byte_out;
  endtask : idle

  task automatic send_region(input logic [15:0] x, input logic [15:0] y, input logic [15:0] w,
                             input logic [15:0] h, input logic allow_zero);
    logic [15:0] v [4];
    v = '{x, y, w, h};
    // Zero width or height only when a refusal is wanted
    if (!allow_zero && (w == 16'h0000 || h == 16'h0000)) begin
      return;
    end
    send_byte(ESC_BYTE);
    send_byte(OP_REGION);
    for (int i = 0; i < 4; i++) begin
      send_byte(v[i][7:0]);
      send_byte(v[i][15:8]);
    end
    idle();
  endtask : send_region
endmodule : prcd_host_model

// [prcd_tb.sv]
// Self-checking testbench for the page region command decoder
`timescale 1ns/1ps
module tb;
  import prcd_pkg::*;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] pitch = 8'h01;
  logic two_inch = 1'b0;
  logic page_set = 1'b0;
  logic std_set = 1'b0;
  logic pg_now = 1'b0;
  logic rot_now = 1'b0;
  wire logic [7:0] cmd_byte;
  wire logic cmd_valid;
  logic [23:0] x_o, y_o, w_o, h_o;
  logic upd, rej, page_o, rot_o, rot_a, rot_d;
  logic [23:0] ex_x = 24'h000000;
  logic [23:0] ex_y = 24'h000000;
  logic [23:0] ex_w = 24'h000000;
  logic [23:0] ex_h = 24'h000000;
  int failures = 0;
  int compares = 0;

  prcd_host_model host (.mclk_in(mclk_in), .cmd_byte_out(cmd_byte), .cmd_valid_out(cmd_valid));

  prcd_decoder #(.PITCH_W(8)) DUT (
    .mclk_in(mclk_in), .reset_in(reset_in), .cmd_byte_in(cmd_byte), .cmd_valid_in(cmd_valid),
    .pitch_in(pitch), .paper_two_inch_in(two_inch), .page_mode_enter_in(page_set),
    .std_mode_enter_in(std_set), .x_start_out(x_o), .y_start_out(y_o), .width_out(w_o),
    .height_out(h_o), .region_update_out(upd), .region_reject_out(rej), .page_mode_out(page_o),
    .rotate_setting_out(rot_o), .rotate_single_byte_alnum_kana_out(rot_a), .rotate_double_byte_out(rot_d)
  );

  initial begin
    forever #20 mclk_in = ~mclk_in;
  end

  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  function automatic logic [23:0] clip(input logic [23:0] s, input logic [23:0] l, input logic [23:0] lim);
    if (s >= lim) return 24'h000000;
    if (s + l > lim) return lim - s;
    return l;
  endfunction : clip

  task automatic check_region();
    chk("x start", x_o, ex_x);
    chk("y start", y_o, ex_y);
    chk("width", w_o, ex_w);
    chk("height", h_o, ex_h);
  endtask : check_region

  // Sends one region command and checks the reject and update pulses and the four results
  task automatic region(input logic [15:0] x, input logic [15:0] y, input logic [15:0] w,
                        input logic [15:0] h, input logic ok);
    logic [23:0] xs, ys, ws, hs, lim;
    lim = two_inch ? 24'(PRINT_W_2IN) : 24'(PRINT_W_3IN);
    xs = 24'(x) * 24'(pitch);
    ys = 24'(y) * 24'(pitch);
    ws = 24'(w) * 24'(pitch);
    hs = 24'(h) * 24'(pitch);
    host.send_region(x, y, w, h, !ok);
    chk("reject pulse", 24'(rej), 24'(!ok));
    @(negedge mclk_in);
    chk("update pulse", 24'(upd), 24'(ok));
    if (ok) begin
      ex_x = xs;
      ex_y = ys;
      ex_w = clip(xs, ws, lim);
      ex_h = clip(ys, hs, 24'(PRINT_H));
    end
    check_region();
  endtask : region

  task automatic check_rot();
    chk("rotation setting", 24'(rot_o), 24'(rot_now));
    chk("rotation single byte", 24'(rot_a), 24'(rot_now & !pg_now));
    chk("rotation double byte", 24'(rot_d), 24'(rot_now & !pg_now));
  endtask : check_rot

  task automatic rotate(input logic [7:0] n, input logic exp_set);
    host.send_byte(ESC_BYTE);
    host.send_byte(OP_ROTATE);
    host.send_byte(n);
    host.idle();
    rot_now = exp_set;
    check_rot();
    @(negedge mclk_in);
  endtask : rotate

  task automatic mode(input logic pg);
    page_set = pg;
    std_set = !pg;
    @(negedge mclk_in);
    page_set = 1'b0;
    std_set = 1'b0;
    pg_now = pg;
    chk("page mode", 24'(page_o), 24'(pg));
    check_rot();
  endtask : mode

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  initial begin
    #400000;
    failures++;
    results();
  end

  initial begin
    logic [7:0] codes [5];
    logic sets [5];
    codes = '{8'h01, 8'h00, 8'h31, 8'h02, 8'h30};
    sets = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    repeat (3) @(negedge mclk_in);
    reset_in = 1'b0;
    check_region();
    check_rot();
    chk("update idle", 24'(upd), 24'h000000);
    region(16'h0102, 16'h0010, 16'h0064, 16'h0020, 1'b1);
    pitch = 8'h03;
    region(16'h0001, 16'h0100, 16'h0005, 16'h0002, 1'b1);
    pitch = 8'h01;
    region(16'd500, 16'd10, 16'd200, 16'd758, 1'b1);
    two_inch = 1'b1;
    region(16'd400, 16'd700, 16'd100, 16'd100, 1'b1);
    region(16'h0005, 16'h0005, 16'h0000, 16'h0007, 1'b0);
    region(16'h0005, 16'h0005, 16'h0007, 16'h0000, 1'b0);
    // Stray byte and an unknown opcode must not derail the next command
    host.send_byte(OP_REGION);
    host.send_byte(ESC_BYTE);
    host.send_byte(8'h58);
    host.idle();
    @(negedge mclk_in);
    region(16'h00ff, 16'h0001, 16'h0100, 16'h0001, 1'b1);
    for (int i = 0; i < 5; i++) begin
      rotate(codes[i], sets[i]);
    end
    mode(1'b1);
    region(16'h0001, 16'h0001, 16'h0001, 16'h0001, 1'b0);
    rotate(8'h31, 1'b1);
    mode(1'b0);
    region(16'h0001, 16'h0001, 16'h0001, 16'h0001, 1'b1);
    @(negedge mclk_in);
    // Reset in mid-run puts every output back to its initial value
    reset_in = 1'b1;
    @(negedge mclk_in);
    reset_in = 1'b0;
    ex_x = 24'h000000;
    ex_y = 24'h000000;
    ex_w = 24'h000000;
    ex_h = 24'h000000;
    rot_now = 1'b0;
    pg_now = 1'b0;
    check_region();
    check_rot();
    chk("page after reset", 24'(page_o), 24'h000000);
    results();
  end
endmodule : tb
